// [rtl/power_mode_pkg.sv]
// constants, field layout and mode codes of the sensor power mode controller
package power_mode_pkg;
    // register offsets on the host register port
    localparam logic [7:0] ADDR_POWER_MODE = 8'hD2;
    localparam logic [7:0] ADDR_NORMAL_INTERVAL = 8'hD3;
    localparam logic [7:0] ADDR_LOW_INTERVAL = 8'hD4;
    localparam logic [7:0] ADDR_ULTRA_INTERVAL = 8'hD5;
    localparam logic [7:0] ADDR_AUTO_TIMER = 8'hD6;
    localparam logic [7:0] ADDR_EVENT_MASK = 8'hD7;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // reset values
    localparam logic [7:0] RST_POWER_MODE = 8'h03;
    localparam logic [7:0] RST_NORMAL_INTERVAL = 8'h10;
    localparam logic [7:0] RST_LOW_INTERVAL = 8'h30;
    localparam logic [7:0] RST_ULTRA_INTERVAL = 8'h08;
    localparam logic [7:0] RST_AUTO_TIMER = 8'h14;
    localparam logic [7:0] RST_EVENT_MASK = 8'h00;

    // power mode settings and event mask fields
    localparam int PWM_ENABLE_BIT = 7;
    localparam int ULTRALOW_AUTO_ALLOW_BIT = 6;
    localparam int AUTO_SWITCH_DISABLE_BIT = 5;
    localparam int MODE_FIELD_HI = 4;
    localparam int MODE_FIELD_LO = 3;
    localparam int SEGMENT_RATE_HI = 2;
    localparam int SEGMENT_RATE_LO = 0;
    localparam int ACTIVE_STATE_MASK_BIT = 7;
    localparam int EVENT_COUNT = 7;

    // manual power mode field codes
    localparam logic [1:0] FIELD_NORMAL = 2'h0;
    localparam logic [1:0] FIELD_LOW = 2'h1;
    localparam logic [1:0] FIELD_ULTRA = 2'h2;
    localparam logic [1:0] FIELD_HALT = 2'h3;

    // timing
    localparam int CLOCK_HZ = 100_000_000;
    localparam int MS_PER_SECOND = 1000;
    localparam int MS_TICK_CYCLES = CLOCK_HZ / MS_PER_SECOND;
    localparam int ULTRA_UNIT_MS = 16;
    localparam int AUTO_UNIT_MS = 500;
    localparam int MIN_REPORT_MS = 4;
    localparam int REPORT_WIDTH = 12;
    localparam int IDLE_WIDTH = 17;
    localparam int SEGMENT_WIDTH = 9;

    // gray order along normal, low, ultra-low
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_LOW = 2'b01,
        MODE_ULTRA = 2'b11,
        MODE_HALT = 2'b10
    } power_mode_t;
endpackage

// [rtl/sensor_power_mode_control.sv]
// power mode selection, report timing, pwm pin takeover and event masking
//
// Summary of operation
// - pwm bit drives third pin, blocks inductive transmit
// - active pwm keeps device out of low and ultra-low power; manual halt still applies
// - allow bit admits ultra-low into automatic switching
// - disable bit stops auto; manual mode needs it
// - field 00 normal rate, 01 low rate
// - field 10 ultra-low, channel zero wakes, segment others
// - field 11 halts conversions until host rewrites
// - segment rate one half down to 1/256
// - normal interval in ms, reset 16
// - intervals under 4 ms get stretched
// - low interval in ms, reset 48
// - ultra-low interval is value times 16 ms
// - auto switch time is value times 500 ms
// - mask bits 6..0 suppress event sources
// - mask bit 7 suppresses absorption active state
`timescale 1ns/100ps
module sensor_power_mode_control #(
    parameter int MS_CYCLES = power_mode_pkg::MS_TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // host register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // sensing side
    input wire logic activityDetect,
    input wire logic pwmWave,
    input wire logic [power_mode_pkg::EVENT_COUNT-1:0] eventSources,
    input wire logic absorptionActiveState,
    // mode and conversion scheduling
    output logic [1:0] powerMode,
    output logic channelZeroCycle,
    output logic otherChannelsCycle,
    // third general pin and inductive transmit
    output logic thirdGeneralPin,
    output logic thirdPinPwmSelect,
    output logic inductiveTransmitEnable,
    // masked events
    output logic [power_mode_pkg::EVENT_COUNT-1:0] maskedEvents,
    output logic absorptionActiveOut
);
    localparam int MSW = $clog2(MS_CYCLES + 1);
    localparam int RW = power_mode_pkg::REPORT_WIDTH;
    localparam int IW = power_mode_pkg::IDLE_WIDTH;
    localparam int SW = power_mode_pkg::SEGMENT_WIDTH;

    if (MS_CYCLES < 1) begin : g_bad_ms
        $error("MS_CYCLES must be at least one");
    end

    // registers
    logic [7:0] powerModeSettings, next_powerModeSettings;
    logic [7:0] normalReportInterval, next_normalReportInterval;
    logic [7:0] lowReportInterval, next_lowReportInterval;
    logic [7:0] ultralowReportInterval, next_ultralowReportInterval;
    logic [7:0] autoSwitchTimer, next_autoSwitchTimer;
    logic [7:0] globalEventMask, next_globalEventMask;
    logic [7:0] next_regRdata;

    // timers and mode
    logic [MSW-1:0] msCount, next_msCount;
    logic msTick;
    power_mode_pkg::power_mode_t mode, next_mode;
    logic [IW-1:0] idleCount, next_idleCount;
    logic [RW-1:0] reportCount, next_reportCount;
    logic [SW-1:0] segmentCount, next_segmentCount;
    logic next_channelZeroCycle, next_otherChannelsCycle;

    // decoded fields
    logic pwmEnable, ultralowAutoAllow, autoSwitchDisable;
    logic [1:0] modeField;
    logic [2:0] segmentRate;
    logic [IW-1:0] idleLimit;
    logic [RW-1:0] reportPeriod;
    logic [SW-1:0] segmentLimit;
    logic reportTick;

    always_comb begin
        pwmEnable = powerModeSettings[power_mode_pkg::PWM_ENABLE_BIT];
        ultralowAutoAllow =
            powerModeSettings[power_mode_pkg::ULTRALOW_AUTO_ALLOW_BIT];
        autoSwitchDisable =
            powerModeSettings[power_mode_pkg::AUTO_SWITCH_DISABLE_BIT];
        modeField = powerModeSettings[power_mode_pkg::MODE_FIELD_HI:
                                      power_mode_pkg::MODE_FIELD_LO];
        segmentRate = powerModeSettings[power_mode_pkg::SEGMENT_RATE_HI:
                                        power_mode_pkg::SEGMENT_RATE_LO];
    end

    // register port: writes land next edge, reads answer next edge
    always_comb begin
        next_powerModeSettings = powerModeSettings;
        next_normalReportInterval = normalReportInterval;
        next_lowReportInterval = lowReportInterval;
        next_ultralowReportInterval = ultralowReportInterval;
        next_autoSwitchTimer = autoSwitchTimer;
        next_globalEventMask = globalEventMask;
        next_regRdata = regRdata;
        if (regWrite) begin
            unique case (regAddr)
                power_mode_pkg::ADDR_POWER_MODE:
                    next_powerModeSettings = regWdata;
                power_mode_pkg::ADDR_NORMAL_INTERVAL:
                    next_normalReportInterval = regWdata;
                power_mode_pkg::ADDR_LOW_INTERVAL:
                    next_lowReportInterval = regWdata;
                power_mode_pkg::ADDR_ULTRA_INTERVAL:
                    next_ultralowReportInterval = regWdata;
                power_mode_pkg::ADDR_AUTO_TIMER:
                    next_autoSwitchTimer = regWdata;
                power_mode_pkg::ADDR_EVENT_MASK:
                    next_globalEventMask = regWdata;
                default: ;
            endcase
        end
        if (regRead) begin
            unique case (regAddr)
                power_mode_pkg::ADDR_POWER_MODE:
                    next_regRdata = powerModeSettings;
                power_mode_pkg::ADDR_NORMAL_INTERVAL:
                    next_regRdata = normalReportInterval;
                power_mode_pkg::ADDR_LOW_INTERVAL:
                    next_regRdata = lowReportInterval;
                power_mode_pkg::ADDR_ULTRA_INTERVAL:
                    next_regRdata = ultralowReportInterval;
                power_mode_pkg::ADDR_AUTO_TIMER:
                    next_regRdata = autoSwitchTimer;
                power_mode_pkg::ADDR_EVENT_MASK:
                    next_regRdata = globalEventMask;
                default:
                    next_regRdata = power_mode_pkg::READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            powerModeSettings <= power_mode_pkg::RST_POWER_MODE;
            normalReportInterval <= power_mode_pkg::RST_NORMAL_INTERVAL;
            lowReportInterval <= power_mode_pkg::RST_LOW_INTERVAL;
            ultralowReportInterval <= power_mode_pkg::RST_ULTRA_INTERVAL;
            autoSwitchTimer <= power_mode_pkg::RST_AUTO_TIMER;
            globalEventMask <= power_mode_pkg::RST_EVENT_MASK;
            regRdata <= power_mode_pkg::READ_UNMAPPED;
        end else begin
            powerModeSettings <= next_powerModeSettings;
            normalReportInterval <= next_normalReportInterval;
            lowReportInterval <= next_lowReportInterval;
            ultralowReportInterval <= next_ultralowReportInterval;
            autoSwitchTimer <= next_autoSwitchTimer;
            globalEventMask <= next_globalEventMask;
            regRdata <= next_regRdata;
        end
    end

    // millisecond time base standing in for the low power oscillator timer
    always_comb begin
        msTick = (msCount == MSW'(MS_CYCLES - 1));
        next_msCount = msTick ? '0 : msCount + MSW'(1);
    end

    // power mode selection
    always_comb begin
        idleLimit = IW'(autoSwitchTimer) *
                    IW'(power_mode_pkg::AUTO_UNIT_MS);
        next_mode = mode;
        next_idleCount = idleCount;
        if (autoSwitchDisable) begin
            next_idleCount = '0;
            unique case (modeField)
                power_mode_pkg::FIELD_NORMAL:
                    next_mode = power_mode_pkg::MODE_NORMAL;
                power_mode_pkg::FIELD_LOW:
                    next_mode = power_mode_pkg::MODE_LOW;
                power_mode_pkg::FIELD_ULTRA:
                    next_mode = power_mode_pkg::MODE_ULTRA;
                power_mode_pkg::FIELD_HALT:
                    next_mode = power_mode_pkg::MODE_HALT;
            endcase
        end else if (activityDetect || mode == power_mode_pkg::MODE_HALT) begin
            next_mode = power_mode_pkg::MODE_NORMAL;
            next_idleCount = '0;
        end else if (msTick) begin
            if (idleCount + IW'(1) >= idleLimit) begin
                next_idleCount = '0;
                if (mode == power_mode_pkg::MODE_NORMAL) begin
                    next_mode = power_mode_pkg::MODE_LOW;
                end else if (ultralowAutoAllow) begin
                    next_mode = power_mode_pkg::MODE_ULTRA;
                end
            end else begin
                next_idleCount = idleCount + IW'(1);
            end
        end
        // leaving ultra-low when it is no longer allowed
        if (!autoSwitchDisable && !ultralowAutoAllow &&
            next_mode == power_mode_pkg::MODE_ULTRA) begin
            next_mode = power_mode_pkg::MODE_LOW;
        end
        // pwm pins the device to normal; halt is still honoured
        if (pwmEnable && (next_mode == power_mode_pkg::MODE_LOW ||
            next_mode == power_mode_pkg::MODE_ULTRA)) begin
            next_mode = power_mode_pkg::MODE_NORMAL;
            next_idleCount = '0;
        end
    end

    // report interval and conversion scheduling
    always_comb begin
        unique case (mode)
            power_mode_pkg::MODE_LOW:
                reportPeriod = RW'(lowReportInterval);
            power_mode_pkg::MODE_ULTRA:
                reportPeriod = RW'(ultralowReportInterval) *
                               RW'(power_mode_pkg::ULTRA_UNIT_MS);
            default:
                reportPeriod = RW'(normalReportInterval);
        endcase
        // short intervals cannot finish setup and comms in time
        if (reportPeriod < RW'(power_mode_pkg::MIN_REPORT_MS)) begin
            reportPeriod = RW'(power_mode_pkg::MIN_REPORT_MS);
        end
        segmentLimit = (SW'(2) << segmentRate) - SW'(1);
        reportTick = 1'b0;
        next_reportCount = reportCount;
        next_segmentCount = segmentCount;
        next_channelZeroCycle = 1'b0;
        next_otherChannelsCycle = 1'b0;
        if (mode == power_mode_pkg::MODE_HALT) begin
            next_reportCount = '0;
            next_segmentCount = '0;
        end else if (msTick) begin
            if (reportCount + RW'(1) >= reportPeriod) begin
                reportTick = 1'b1;
                next_reportCount = '0;
            end else begin
                next_reportCount = reportCount + RW'(1);
            end
        end
        if (reportTick) begin
            next_channelZeroCycle = 1'b1;
            if (mode == power_mode_pkg::MODE_ULTRA) begin
                if (segmentCount >= segmentLimit) begin
                    next_segmentCount = '0;
                    next_otherChannelsCycle = 1'b1;
                end else begin
                    next_segmentCount = segmentCount + SW'(1);
                end
            end else begin
                next_segmentCount = '0;
                next_otherChannelsCycle = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            msCount <= '0;
            mode <= power_mode_pkg::MODE_NORMAL;
            idleCount <= '0;
            reportCount <= '0;
            segmentCount <= '0;
            channelZeroCycle <= 1'b0;
            otherChannelsCycle <= 1'b0;
        end else begin
            msCount <= next_msCount;
            mode <= next_mode;
            idleCount <= next_idleCount;
            reportCount <= next_reportCount;
            segmentCount <= next_segmentCount;
            channelZeroCycle <= next_channelZeroCycle;
            otherChannelsCycle <= next_otherChannelsCycle;
        end
    end

    // pin takeover and event masking, all registered
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            powerMode <= power_mode_pkg::MODE_NORMAL;
            thirdGeneralPin <= 1'b0;
            thirdPinPwmSelect <= 1'b0;
            inductiveTransmitEnable <= 1'b1;
            maskedEvents <= '0;
            absorptionActiveOut <= 1'b0;
        end else begin
            powerMode <= next_mode;
            thirdGeneralPin <= pwmEnable & pwmWave;
            thirdPinPwmSelect <= pwmEnable;
            inductiveTransmitEnable <= !pwmEnable;
            maskedEvents <= eventSources &
                ~globalEventMask[power_mode_pkg::EVENT_COUNT-1:0];
            absorptionActiveOut <= absorptionActiveState &
                !globalEventMask[power_mode_pkg::ACTIVE_STATE_MASK_BIT];
        end
    end
endmodule

// [verification/sensor_power_mode_control_assertions.sv]
// port-level assertions for the sensor power mode controller
`timescale 1ns/100ps
module sensor_power_mode_control_assertions #(
    parameter int MS_CYCLES = power_mode_pkg::MS_TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // inputs watched
    input wire logic regWrite,
    input wire logic pwmWave,
    input wire logic [6:0] eventSources,
    input wire logic absorptionActiveState,
    // outputs watched
    input wire logic [1:0] powerMode,
    input wire logic channelZeroCycle,
    input wire logic otherChannelsCycle,
    input wire logic thirdGeneralPin,
    input wire logic thirdPinPwmSelect,
    input wire logic inductiveTransmitEnable,
    input wire logic [6:0] maskedEvents,
    input wire logic absorptionActiveOut
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_pin_owner_split: assert property (
        thirdPinPwmSelect != inductiveTransmitEnable)
        else $error("pin owned by both or neither");
    a_pin_follows_pwm: assert property (
        thirdPinPwmSelect |-> thirdGeneralPin == $past(pwmWave))
        else $error("pin does not follow pwm wave");
    a_pin_idle_low: assert property (
        !thirdPinPwmSelect |-> !thirdGeneralPin)
        else $error("pin driven while pwm off");
    a_pwm_keeps_normal: assert property (
        thirdPinPwmSelect && $past(thirdPinPwmSelect) |->
        powerMode inside {power_mode_pkg::MODE_NORMAL,
        power_mode_pkg::MODE_HALT})
        else $error("low power mode under pwm");
    a_events_masked: assert property (
        (maskedEvents & ~$past(eventSources)) == 7'h00)
        else $error("event without a source");
    a_active_masked: assert property (
        absorptionActiveOut |-> $past(absorptionActiveState))
        else $error("active state without a source");
    a_halt_quiet: assert property (
        powerMode == power_mode_pkg::MODE_HALT &&
        $past(powerMode, 2) == power_mode_pkg::MODE_HALT |->
        !channelZeroCycle && !otherChannelsCycle)
        else $error("conversion while halted");
    a_halt_holds: assert property (
        powerMode == power_mode_pkg::MODE_HALT && !regWrite &&
        !$past(regWrite) |=> powerMode == power_mode_pkg::MODE_HALT)
        else $error("halt left without a host write");
    a_other_with_zero: assert property (
        otherChannelsCycle |-> channelZeroCycle)
        else $error("segment pulse without wake pulse");
    a_pulse_spacing: assert property (
        channelZeroCycle |=> !channelZeroCycle [*8])
        else $error("report pulses too close");
endmodule

bind sensor_power_mode_control sensor_power_mode_control_assertions #(
    .MS_CYCLES(MS_CYCLES)
) sensor_power_mode_control_assertions_inst (.ref_clk, .rst_n, .regWrite,
    .pwmWave, .eventSources, .absorptionActiveState, .powerMode,
    .channelZeroCycle, .otherChannelsCycle, .thirdGeneralPin,
    .thirdPinPwmSelect, .inductiveTransmitEnable, .maskedEvents,
    .absorptionActiveOut);

// [verification/host_model.sv]
// host side model driving the register port
`timescale 1ns/100ps
module host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata,
    input wire logic [7:0] regRdata
);
    initial begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'h00;
    end
    // released data inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 regWrite = 1'b1;
        regAddr = a;
        regWdata = d;
        @(posedge ref_clk);
        #1 regWrite = 1'b0;
        regWdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1 regRead = 1'b1;
        regAddr = a;
        @(posedge ref_clk);
        #1 regRead = 1'b0;
        @(posedge ref_clk);
        #1 d = regRdata;
    endtask
endmodule

// [verification/sensor_power_mode_control_tb.sv]
// self-checking bench for the sensor power mode controller
`timescale 1ns/100ps
module sensor_power_mode_control_tb;
    localparam int MSC = 10;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pwmWave = 1'b0;
    logic regWrite, regRead, activityDetect, absorptionActiveState;
    logic [7:0] regAddr, regWdata, regRdata, rd;
    logic [6:0] eventSources, maskedEvents;
    logic [1:0] powerMode;
    logic channelZeroCycle, otherChannelsCycle, thirdGeneralPin;
    logic thirdPinPwmSelect, inductiveTransmitEnable, absorptionActiveOut;
    int n_errors = 0;
    int checked = 0;
    int n;
    logic [7:0] rstVal[6] = '{8'h03, 8'h10, 8'h30, 8'h08, 8'h14, 8'h00};
    logic [1:0] fieldMode[4] = '{power_mode_pkg::MODE_NORMAL,
        power_mode_pkg::MODE_LOW, power_mode_pkg::MODE_ULTRA,
        power_mode_pkg::MODE_HALT};
    row_t rows[9] = '{'{8'hD3, 8'h05, 8'h05}, '{8'hD4, 8'h06, 8'h06},
        '{8'hD5, 8'h01, 8'h01}, '{8'hD6, 8'h01, 8'h01},
        '{8'hD7, 8'h55, 8'h55}, '{8'hD7, 8'h80, 8'h80},
        '{8'hD7, 8'h00, 8'h00}, '{8'hD8, 8'hAA, 8'h00},
        '{8'hD2, 8'h20, 8'h20}};

    sensor_power_mode_control #(
        .MS_CYCLES(MSC)
    ) sensor_power_mode_control_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata), .activityDetect(activityDetect),
        .pwmWave(pwmWave), .eventSources(eventSources),
        .absorptionActiveState(absorptionActiveState),
        .powerMode(powerMode), .channelZeroCycle(channelZeroCycle),
        .otherChannelsCycle(otherChannelsCycle),
        .thirdGeneralPin(thirdGeneralPin),
        .thirdPinPwmSelect(thirdPinPwmSelect),
        .inductiveTransmitEnable(inductiveTransmitEnable),
        .maskedEvents(maskedEvents),
        .absorptionActiveOut(absorptionActiveOut));
    host_model host_model_inst (.ref_clk(ref_clk), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .regRdata(regRdata));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    always begin
        repeat (3) @(posedge ref_clk);
        #1 pwmWave = ~pwmWave;
    end

    task automatic print_verdict();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic settle();
        @(posedge ref_clk);
        #1;
    endtask
    // 0 wake pulse, 1 segment pulse, 2 mode equal to m
    task automatic waitFor(input int w, input logic [1:0] m, output int c);
        logic hit;
        c = 0;
        do begin
            settle();
            c++;
            hit = w == 0 ? channelZeroCycle :
                w == 1 ? otherChannelsCycle : powerMode === m;
        end while (hit !== 1'b1 && c < 20000);
        if (c >= 20000) begin
            n_errors++;
            $display("[FAIL] %0t wait ran out", $time);
            print_verdict();
        end
    endtask
    task automatic period(input int w, input int ms);
        waitFor(w, 2'h0, n);
        waitFor(w, 2'h0, n);
        chk(n, ms * MSC);
    endtask
    task automatic pulseActivity();
        activityDetect = 1'b1;
        settle();
        activityDetect = 1'b0;
    endtask

    initial begin
        eventSources = 7'h7F;
        absorptionActiveState = 1'b1;
        activityDetect = 1'b0;
        repeat (12) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        foreach (rstVal[i]) begin
            host_model_inst.rd(8'hD2 + 8'(i), rd);
            chk(rd, rstVal[i]);
        end
        chk(inductiveTransmitEnable, 1);
        foreach (rows[i]) begin
            host_model_inst.wr(rows[i].a, rows[i].d);
            host_model_inst.rd(rows[i].a, rd);
            chk(rd, rows[i].e);
            if (rows[i].a == 8'hD7) begin
                rd = ~rows[i].d;
                chk({absorptionActiveOut, maskedEvents}, rd);
            end
        end
        // idle sources must stay quiet with nothing masked
        eventSources = 7'h2A;
        absorptionActiveState = 1'b0;
        settle();
        chk({absorptionActiveOut, maskedEvents}, 8'h2A);
        eventSources = 7'h7F;
        absorptionActiveState = 1'b1;
        foreach (fieldMode[f]) begin
            host_model_inst.wr(8'hD2, 8'h20 | 8'(f << 3));
            settle();
            chk(powerMode, fieldMode[f]);
        end
        n = 0;
        repeat (700) begin
            settle();
            if (channelZeroCycle || otherChannelsCycle) n++;
        end
        chk(n, 0);
        host_model_inst.wr(8'hD2, 8'h20);
        settle();
        chk(powerMode, power_mode_pkg::MODE_NORMAL);
        period(0, 5);
        period(1, 5);
        host_model_inst.wr(8'hD3, 8'h02);
        period(0, 4);
        host_model_inst.wr(8'hD2, 8'h28);
        period(0, 6);
        for (int r = 0; r < 2; r++) begin
            host_model_inst.wr(8'hD2, 8'h30 | 8'(r));
            period(1, 16 * (2 << r));
            period(0, 16);
        end
        // slowest segment rate; zero interval clamps to keep the run short
        host_model_inst.wr(8'hD5, 8'h00);
        host_model_inst.wr(8'hD2, 8'h37);
        period(1, 4 * 256);
        host_model_inst.wr(8'hD2, 8'h00);
        pulseActivity();
        waitFor(2, power_mode_pkg::MODE_LOW, n);
        chk(n >= 4980 && n <= 5020, 1);
        repeat (6000) settle();
        chk(powerMode, power_mode_pkg::MODE_LOW);
        host_model_inst.wr(8'hD2, 8'h40);
        waitFor(2, power_mode_pkg::MODE_ULTRA, n);
        chk(n <= 5020, 1);
        pulseActivity();
        settle();
        chk(powerMode, power_mode_pkg::MODE_NORMAL);
        host_model_inst.wr(8'hD2, 8'hC0);
        repeat (6000) settle();
        chk(powerMode, power_mode_pkg::MODE_NORMAL);
        chk({thirdPinPwmSelect, inductiveTransmitEnable}, 2'b10);
        // sample the wave away from the edge where it toggles
        repeat (8) begin
            #3 rd = {7'h00, pwmWave};
            settle();
            chk(thirdGeneralPin, rd);
        end
        // reset in mid-run drops the pin takeover and the settings
        rst_n = 1'b0;
        repeat (3) settle();
        chk({powerMode, thirdPinPwmSelect, inductiveTransmitEnable,
            thirdGeneralPin}, 5'h02);
        rst_n = 1'b1;
        host_model_inst.rd(8'hD2, rd);
        chk(rd, 8'h03);
        print_verdict();
    end
endmodule
